// ===== serial_port_pkg.sv
// Constants, register layouts and shared functions of the asynchronous serial port.
package serial_port_pkg;

  localparam logic [15:0] ADDR_DATA   = 16'hFF18;
  localparam logic [15:0] ADDR_MODE   = 16'hFF70;
  localparam logic [15:0] ADDR_STATUS = 16'hFF71;
  localparam logic [15:0] ADDR_BAUD   = 16'hFF72;

  localparam logic [7:0] MODE_RESET   = 8'h00;
  localparam logic [7:0] BAUD_RESET   = 8'h00;
  localparam logic [2:0] STATUS_RESET = 3'h0;
  localparam logic [7:0] RXBUF_RESET  = 8'hFF;

  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD  = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;

  localparam logic [4:0] BAUD_BASE_DIV = 5'h10;
  localparam int         PRESC_EXP_MIN = 2;
  localparam logic [3:0] MDL_PROHIBIT  = 4'hF;
  localparam logic [3:0] MDL_MAX       = 4'hE;
  localparam int         FIFO_WIDTH    = 8;
  localparam int         FIFO_DEPTH    = 16;

  typedef struct packed {
    logic       tx_enable_bit;
    logic       rx_enable_bit;
    logic [1:0] parity_sel;
    logic       char_length_bit;
    logic       stop_length_bit;
    logic       err_irq_mask_bit;
    logic       fixed_zero;
  } serial_mode_t;

  typedef struct packed {
    logic       fixed_zero;
    logic [2:0] src_sel;
    logic [3:0] div_sel;
  } baud_ctrl_t;

  typedef struct packed {
    logic parity_error_flag;
    logic framing_error_flag;
    logic overrun_error_flag;
  } rx_status_t;

  // Parity over the active data bits; the fixed-zero mode always yields zero.
  function automatic logic parity_calc(input logic [7:0] data, input serial_mode_t mode);
    logic [7:0] bits;
    bits = mode.char_length_bit ? data : {1'b0, data[6:0]};
    case (mode.parity_sel)
      PAR_ODD:  parity_calc = ~(^bits);
      PAR_EVEN: parity_calc = ^bits;
      default:  parity_calc = 1'b0;
    endcase
  endfunction : parity_calc

endpackage : serial_port_pkg

// ===== tx_fifo.sv
// Parameterised first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/10ps
`default_nettype none
module tx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             sys_clk_in,
  input  wire logic             rst_n_in,
  // Filling side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Draining side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_ptr_q;
  logic [PW-1:0]    rd_ptr_q;
  logic [PW:0]      count_q;
  logic             push;
  logic             pop;

  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;
  assign in_ready_out  = (count_q != (PW+1)'(DEPTH));
  assign out_valid_out = (count_q != '0);
  assign out_data_out  = mem_q[rd_ptr_q];

  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + PW'(1);
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + PW'(1);
      end
      count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  fifo_bound_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    count_q <= (PW+1)'(DEPTH))
    else $error("fifo count ran past its depth");

endmodule : tx_fifo
`default_nettype wire

// ===== async_serial_port.sv
// Asynchronous serial port: register file, baud generator, transmitter and receiver.
`timescale 1ns/10ps
`default_nettype none
module async_serial_port (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  // CPU memory access
  input  wire logic [15:0] cpu_addr_in,
  input  wire logic        cpu_wr_in,
  input  wire logic        cpu_rd_in,
  input  wire logic [7:0]  cpu_wdata_in,
  output logic      [7:0]  cpu_rdata_out,
  output logic             cpu_tx_ready_out,
  // Serial pins
  input  wire logic        rxd_in,
  output logic             txd_out,
  output logic             tx_pin_serial_out,
  output logic             rx_pin_serial_out,
  // Completion pulses
  output logic             rx_done_irq_out,
  output logic             tx_done_irq_out
);
  import serial_port_pkg::*;

  typedef enum logic [4:0] {
    TX_IDLE  = 5'h01,
    TX_START = 5'h02,
    TX_DATA  = 5'h04,
    TX_PAR   = 5'h08,
    TX_STOP  = 5'h10
  } tx_state_t;

  typedef enum logic [4:0] {
    RX_IDLE  = 5'h01,
    RX_START = 5'h02,
    RX_DATA  = 5'h04,
    RX_PAR   = 5'h08,
    RX_STOP  = 5'h10
  } rx_state_t;

  serial_mode_t mode_q;
  baud_ctrl_t   baud_q;
  rx_status_t   status_q;
  logic [7:0]   rx_buffer_q;
  logic         unread_q;
  logic [7:0]   rdata_q;

  // Register access.
  logic wr_data;
  logic rd_data;
  assign wr_data = cpu_wr_in && (cpu_addr_in == ADDR_DATA);
  assign rd_data = cpu_rd_in && (cpu_addr_in == ADDR_DATA);

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      mode_q <= MODE_RESET;
      baud_q <= BAUD_RESET;
    end else if (cpu_wr_in) begin
      if (cpu_addr_in == ADDR_MODE) begin
        mode_q <= {cpu_wdata_in[7:1], 1'b0};
      end
      if (cpu_addr_in == ADDR_BAUD) begin
        baud_q <= {1'b0, cpu_wdata_in[6:0]};
      end
    end
  end

  // A read at the shared data address sees the receive buffer, never the transmit register.
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      rdata_q <= 8'h00;
    end else if (cpu_rd_in) begin
      case (cpu_addr_in)
        ADDR_DATA:   rdata_q <= rx_buffer_q;
        ADDR_MODE:   rdata_q <= mode_q;
        ADDR_STATUS: rdata_q <= {5'h00, status_q};
        ADDR_BAUD:   rdata_q <= baud_q;
        default:     rdata_q <= 8'h00;
      endcase
    end
  end

  // Baud generator.
  logic [8:0] presc_q;
  logic [8:0] presc_mask;
  logic       fsck_tick;
  logic [4:0] bit_div;
  logic [4:0] bit_half;
  assign presc_mask = 9'((10'h004 << baud_q.src_sel) - 10'h001);
  assign fsck_tick  = ((presc_q & presc_mask) == presc_mask);
  // The prohibited divider code is clamped to the slowest legal one instead of misbehaving.
  assign bit_div  = BAUD_BASE_DIV + ((baud_q.div_sel == MDL_PROHIBIT) ? {1'b0, MDL_MAX}
                                                                      : {1'b0, baud_q.div_sel});
  assign bit_half = {1'b0, bit_div[4:1]};

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      presc_q <= 9'h000;
    end else begin
      presc_q <= presc_q + 9'h001;
    end
  end

  // Transmit path: CPU writes queue in the buffer and the shifter drains it.
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic       fifo_out_ready;
  logic [7:0] fifo_out_data;

  tx_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .sys_clk_in    (sys_clk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (wr_data && mode_q.tx_enable_bit),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (cpu_wdata_in),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_out_ready),
    .out_data_out  (fifo_out_data)
  );

  tx_state_t  tx_st_q;
  logic [7:0] tx_shift_reg_q;
  logic [4:0] tx_cnt_q;
  logic [2:0] tx_bit_q;
  logic       tx_stop2_q;
  logic       tx_bit_end;
  logic       txd_q;
  logic       tx_done_q;

  assign fifo_out_ready = (tx_st_q == TX_IDLE) && mode_q.tx_enable_bit;
  assign tx_bit_end     = fsck_tick && (tx_cnt_q == bit_div - 5'h01);

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in || tx_st_q == TX_IDLE) begin
      tx_cnt_q <= 5'h00;
    end else if (fsck_tick) begin
      tx_cnt_q <= tx_bit_end ? 5'h00 : tx_cnt_q + 5'h01;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      tx_st_q        <= TX_IDLE;
      tx_shift_reg_q <= 8'h00;
      tx_bit_q       <= 3'h0;
      tx_stop2_q     <= 1'b0;
      tx_done_q      <= 1'b0;
    end else if (!mode_q.tx_enable_bit) begin
      tx_st_q   <= TX_IDLE;
      tx_done_q <= 1'b0;
    end else begin
      tx_done_q <= 1'b0;
      case (tx_st_q)
        TX_IDLE: begin
          if (fifo_out_valid) begin
            tx_shift_reg_q <= fifo_out_data;
            tx_bit_q       <= 3'h0;
            tx_st_q        <= TX_START;
          end
        end
        TX_START: begin
          if (tx_bit_end) begin
            tx_st_q <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (tx_bit_end) begin
            tx_bit_q <= tx_bit_q + 3'h1;
            // Only bits 0 to 6 leave the pin for short characters.
            if (tx_bit_q == (mode_q.char_length_bit ? 3'h7 : 3'h6)) begin
              tx_st_q    <= (mode_q.parity_sel == PAR_NONE) ? TX_STOP : TX_PAR;
              tx_stop2_q <= mode_q.stop_length_bit;
            end
          end
        end
        TX_PAR: begin
          if (tx_bit_end) begin
            tx_st_q <= TX_STOP;
          end
        end
        TX_STOP: begin
          if (tx_bit_end) begin
            if (tx_stop2_q) begin
              tx_stop2_q <= 1'b0;
            end else begin
              tx_st_q   <= TX_IDLE;
              tx_done_q <= 1'b1;
            end
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      txd_q <= 1'b1;
    end else begin
      case (tx_st_q)
        TX_START: txd_q <= 1'b0;
        TX_DATA:  txd_q <= tx_shift_reg_q[tx_bit_q];
        TX_PAR:   txd_q <= parity_calc(tx_shift_reg_q, mode_q);
        default:  txd_q <= 1'b1;
      endcase
    end
  end

  // Receive path; the pin is foreign to this clock and is synchronised first.
  logic       rx_s1_q;
  logic       rx_s2_q;
  logic       rx_prev_q;
  rx_state_t  rx_st_q;
  logic [7:0] rx_shift_reg_q;
  logic [4:0] rx_cnt_q;
  logic [2:0] rx_bit_q;
  logic       rx_par_err_q;
  logic       rx_sample;
  logic       rx_done;
  logic       rx_frame_err;
  logic       rx_err;
  logic       rx_irq_q;

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      rx_s1_q   <= 1'b1;
      rx_s2_q   <= 1'b1;
      rx_prev_q <= 1'b1;
    end else begin
      rx_s1_q   <= rxd_in;
      rx_s2_q   <= rx_s1_q;
      rx_prev_q <= rx_s2_q;
    end
  end

  assign rx_sample = fsck_tick && (rx_cnt_q == bit_half);

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in || rx_st_q == RX_IDLE) begin
      rx_cnt_q <= 5'h00;
    end else if (fsck_tick) begin
      rx_cnt_q <= (rx_cnt_q == bit_div - 5'h01) ? 5'h00 : rx_cnt_q + 5'h01;
    end
  end

  // Only the first stop bit is examined, whatever the transmit stop length.
  assign rx_done      = (rx_st_q == RX_STOP) && rx_sample;
  assign rx_frame_err = !rx_s2_q;
  assign rx_err       = rx_par_err_q || rx_frame_err || unread_q;

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      rx_st_q        <= RX_IDLE;
      rx_shift_reg_q <= 8'h00;
      rx_bit_q       <= 3'h0;
      rx_par_err_q   <= 1'b0;
    end else if (!mode_q.rx_enable_bit) begin
      rx_st_q <= RX_IDLE;
    end else begin
      case (rx_st_q)
        RX_IDLE: begin
          if (rx_prev_q && !rx_s2_q) begin
            rx_st_q      <= RX_START;
            rx_bit_q     <= 3'h0;
            rx_par_err_q <= 1'b0;
          end
        end
        RX_START: begin
          if (rx_sample) begin
            rx_st_q <= rx_s2_q ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_sample) begin
            rx_shift_reg_q <= {rx_s2_q, rx_shift_reg_q[7:1]};
            rx_bit_q       <= rx_bit_q + 3'h1;
            if (rx_bit_q == (mode_q.char_length_bit ? 3'h7 : 3'h6)) begin
              rx_st_q <= (mode_q.parity_sel == PAR_NONE) ? RX_STOP : RX_PAR;
            end
          end
        end
        RX_PAR: begin
          if (rx_sample) begin
            rx_st_q <= RX_STOP;
            // The fixed-zero parity setting skips the check.
            rx_par_err_q <= mode_q.parity_sel[1] &&
                            (rx_s2_q != parity_calc(rx_buffer_next(), mode_q));
          end
        end
        RX_STOP: begin
          if (rx_sample) begin
            rx_st_q <= RX_IDLE;
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // Aligns the shifted-in bits; short characters get a zero top bit.
  function automatic logic [7:0] rx_buffer_next();
    rx_buffer_next = mode_q.char_length_bit ? rx_shift_reg_q : {1'b0, rx_shift_reg_q[7:1]};
  endfunction : rx_buffer_next

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      rx_buffer_q <= RXBUF_RESET;
    end else if (rx_done) begin
      rx_buffer_q <= rx_buffer_next();
    end
  end

  // A completing character beats a same-cycle buffer read, so no overrun is lost.
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      status_q <= STATUS_RESET;
      unread_q <= 1'b0;
    end else begin
      if (rx_done) begin
        status_q.parity_error_flag  <= rx_par_err_q;
        status_q.framing_error_flag <= rx_frame_err;
        unread_q                    <= 1'b1;
      end else if (rd_data) begin
        unread_q <= 1'b0;
      end
      if (rx_done && unread_q) begin
        status_q.overrun_error_flag <= 1'b1;
      end else if (rd_data) begin
        status_q.overrun_error_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      rx_irq_q <= 1'b0;
    end else begin
      rx_irq_q <= rx_done && !(rx_err && mode_q.err_irq_mask_bit);
    end
  end

  // Output registers.
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      cpu_tx_ready_out  <= 1'b0;
      tx_pin_serial_out <= 1'b0;
      rx_pin_serial_out <= 1'b0;
    end else begin
      cpu_tx_ready_out  <= fifo_in_ready && mode_q.tx_enable_bit;
      tx_pin_serial_out <= mode_q.tx_enable_bit;
      rx_pin_serial_out <= mode_q.rx_enable_bit;
    end
  end

  assign cpu_rdata_out   = rdata_q;
  assign txd_out         = txd_q;
  assign rx_done_irq_out = rx_irq_q;
  assign tx_done_irq_out = tx_done_q;

  start_bit_low_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    $rose(tx_st_q == TX_START) |=> !txd_q)
    else $error("start bit not driven low");
  rxbuf_reset_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    $rose(rst_n_in) |-> (rx_buffer_q == RXBUF_RESET))
    else $error("receive buffer not all ones after reset");
  mode_reset_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    $rose(rst_n_in) |-> (mode_q == MODE_RESET) && !tx_pin_serial_out)
    else $error("mode register not cleared by reset");
  rx_msb_zero_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (rx_done && !mode_q.char_length_bit) |=> !rx_buffer_q[7])
    else $error("short character left top bit set");
  shared_read_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    rd_data |=> (cpu_rdata_out == $past(rx_buffer_q)))
    else $error("data address read did not return receive buffer");
  overrun_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (status_q.overrun_error_flag && !rd_data) |=> status_q.overrun_error_flag)
    else $error("overrun flag dropped before buffer read");
  rx_irq_gate_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    rx_done |=> (rx_done_irq_out == !($past(rx_err) && mode_q.err_irq_mask_bit)))
    else $error("reception interrupt gating wrong");
  txd_idle_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (tx_st_q == TX_IDLE) [*2] |-> txd_q)
    else $error("transmit pin not idle high");
  tx_done_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    tx_done_irq_out |-> (tx_st_q == TX_IDLE) && txd_q)
    else $error("transmit complete raised outside idle");

endmodule : async_serial_port
`default_nettype wire

// ===== serial_station.sv
// Remote serial station: drives the receive line and decodes frames seen on the transmit line.
`timescale 1ns/10ps
`default_nettype none
module serial_station #(
  parameter int BIT = 64
) (
  input  wire logic       sys_clk_in,
  input  wire logic       line_in,
  input  wire logic [3:0] frame_bits_in,
  output logic            line_out
);
  logic [11:0] frames_q[$];
  logic [11:0] v;

  initial begin
    line_out = 1'b1;
  end

  task automatic put(input logic b);
    line_out = b;
    repeat (BIT) @(posedge sys_clk_in);
    #1;
  endtask : put

  // Called just after a clock edge, so every line change stays clear of the sampling edge.
  task automatic send(input logic [7:0] d, input int n, input logic pen, input logic pv,
                      input logic stop);
    put(1'b0);
    for (int i = 0; i < n; i++) begin
      put(d[i]);
    end
    if (pen) begin
      put(pv);
    end
    put(stop);
    line_out = 1'b1;
  endtask : send

  // Samples mid-bit after each start; bits beyond the frame read as zero.
  always begin
    @(negedge line_in);
    repeat (BIT / 2) @(posedge sys_clk_in);
    if (line_in == 1'b0) begin
      v = 12'h000;
      for (int i = 0; i < frame_bits_in; i++) begin
        repeat (BIT) @(posedge sys_clk_in);
        v[i] = line_in;
      end
      frames_q.push_back(v);
    end
  end
endmodule : serial_station
`default_nettype wire

// ===== async_serial_port_test.sv
// Self-checking testbench of the asynchronous serial port.
`timescale 1ns/10ps
`default_nettype none
module async_serial_port_test;
  import serial_port_pkg::*;
  logic        sys_clk_in, rst_n_in, cpu_wr_in, cpu_rd_in, rxd_line, cpu_tx_ready_out, txd_out;
  logic        tx_pin_serial_out, rx_pin_serial_out, rx_done_irq_out, tx_done_irq_out;
  logic [15:0] cpu_addr_in;
  logic [7:0]  cpu_wdata_in, cpu_rdata_out, v, last_rx;
  logic [7:0]  data_q[17];
  logic [3:0]  frame_bits;
  int          fails, cmp_count, rx_pulses, tx_pulses, target, lo;
  integer      seed;

  async_serial_port dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .cpu_addr_in(cpu_addr_in),
    .cpu_wr_in(cpu_wr_in), .cpu_rd_in(cpu_rd_in), .cpu_wdata_in(cpu_wdata_in),
    .cpu_rdata_out(cpu_rdata_out), .cpu_tx_ready_out(cpu_tx_ready_out), .rxd_in(rxd_line),
    .txd_out(txd_out), .tx_pin_serial_out(tx_pin_serial_out),
    .rx_pin_serial_out(rx_pin_serial_out), .rx_done_irq_out(rx_done_irq_out),
    .tx_done_irq_out(tx_done_irq_out));
  // The station stands where the port has the receive pin as input, transmit as output.
  serial_station #(.BIT(64)) st (.sys_clk_in(sys_clk_in), .line_in(txd_out),
    .frame_bits_in(frame_bits), .line_out(rxd_line));

  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  always @(posedge sys_clk_in) begin
    if (rx_done_irq_out === 1'b1) rx_pulses++;
    if (tx_done_irq_out === 1'b1) tx_pulses++;
  end

  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    // One edge between calls keeps each strobe at a single value per time step.
    @(posedge sys_clk_in);
    #1;
    cpu_addr_in = a;
    cpu_wdata_in = d;
    cpu_wr_in = 1'b1;
    @(posedge sys_clk_in);
    #1;
    cpu_wr_in = 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge sys_clk_in);
    #1;
    cpu_addr_in = a;
    cpu_rd_in = 1'b1;
    @(posedge sys_clk_in);
    #1;
    cpu_rd_in = 1'b0;
    d = cpu_rdata_out;
  endtask : rd

  // Configuration code: bits 1:0 parity, bit 2 eight-bit characters, bit 3 two stop bits.
  function automatic logic [7:0] mode_of(input logic tx, input logic rx, input logic [3:0] c,
                                         input logic m);
    return {tx, rx, c[1:0], c[2], c[3], m, 1'b0};
  endfunction : mode_of

  function automatic logic exp_par(input logic [7:0] d, input logic [3:0] c);
    logic [7:0] b;
    b = c[2] ? d : {1'b0, d[6:0]};
    return (c[1:0] == 2'h2) ? ~(^b) : (c[1:0] == 2'h3) ? ^b : 1'b0;
  endfunction : exp_par

  task automatic wait_tx(input int tgt);
    int k;
    for (k = 0; k < 20000 && tx_pulses < tgt; k++) @(posedge sys_clk_in);
    #1;
    if (tx_pulses < tgt) begin
      fails++;
      $display("mismatch transmit completion expected pulse seen none");
      results();
    end
  endtask : wait_tx

  task automatic rx_one(input logic [7:0] d, input logic [3:0] c, input logic flip,
                        input logic stop, input logic m, input logic [2:0] st_exp,
                        input logic pulse, input logic rd_data);
    int p0;
    wr(ADDR_MODE, mode_of(1'b0, 1'b1, c, m));
    p0 = rx_pulses;
    st.send(d, c[2] ? 8 : 7, c[1:0] != 2'h0, exp_par(d, c) ^ flip, stop);
    repeat (4) @(posedge sys_clk_in);
    #1;
    check("rx pulse", 12'(rx_pulses - p0), {11'h0, pulse});
    rd(ADDR_STATUS, v);
    check("status", {4'h0, v}, {9'h0, st_exp});
    last_rx = c[2] ? d : {1'b0, d[6:0]};
    if (rd_data) begin
      rd(ADDR_DATA, v);
      check("rx data", {4'h0, v}, {4'h0, last_rx});
    end
  endtask : rx_one

  task automatic tx_one(input logic [7:0] d, input logic [3:0] c);
    int n;
    logic [11:0] e;
    wr(ADDR_MODE, mode_of(1'b1, 1'b1, c, 1'b0));
    n = c[2] ? 8 : 7;
    e = {4'h0, d};
    if (!c[2]) e[7] = 1'b0;
    if (c[1:0] != 2'h0) begin
      e[n] = exp_par(d, c);
      n++;
    end
    e[n] = 1'b1;
    if (c[3]) e[n + 1] = 1'b1;
    frame_bits = 4'(n + 1 + int'(c[3]));
    target = tx_pulses + 1;
    wr(ADDR_DATA, d);
    wait_tx(target);
    check("frame count", 12'(st.frames_q.size()), 12'h001);
    if (st.frames_q.size() > 0) check("frame", st.frames_q.pop_front(), e);
    check("txd idle", {11'h0, txd_out}, 12'h001);
    rd(ADDR_DATA, v);
    check("data read", {4'h0, v}, {4'h0, last_rx});
  endtask : tx_one

  initial begin
    seed = 32'hBBFB362C;
    cpu_addr_in = 16'h0000;
    cpu_wr_in = 1'b0;
    cpu_rd_in = 1'b0;
    cpu_wdata_in = 8'h00;
    frame_bits = 4'hA;
    rst_n_in = 1'b0;
    repeat (4) @(posedge sys_clk_in);
    #1;
    rst_n_in = 1'b1;
    check("pins", {10'h0, tx_pin_serial_out, rx_pin_serial_out}, 12'h000);
    rd(ADDR_MODE, v);
    check("mode reset", {4'h0, v}, 12'h000);
    rd(ADDR_DATA, v);
    check("rx buffer reset", {4'h0, v}, 12'h0FF);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_MODE, {k[1:0], 6'h01});
      @(posedge sys_clk_in);
      #1;
      check("pins", {10'h0, tx_pin_serial_out, rx_pin_serial_out}, 12'(k));
      rd(ADDR_MODE, v);
      check("mode", {4'h0, v}, {4'h0, k[1:0], 6'h00});
    end
    for (int i = 0; i < 16; i++) rx_one(8'($random(seed)), 4'(i), 1'b0, 1'b1, 1'b0, 3'h0, 1'b1, 1'b1);
    rx_one(8'h5A, 4'h6, 1'b1, 1'b1, 1'b0, 3'h4, 1'b1, 1'b1);
    rx_one(8'hC3, 4'h7, 1'b1, 1'b1, 1'b1, 3'h4, 1'b0, 1'b1);
    rx_one(8'h81, 4'h4, 1'b0, 1'b0, 1'b0, 3'h2, 1'b1, 1'b1);
    rx_one(8'h81, 4'hD, 1'b1, 1'b1, 1'b0, 3'h0, 1'b1, 1'b1);
    rx_one(8'h11, 4'h4, 1'b0, 1'b1, 1'b0, 3'h0, 1'b1, 1'b0);
    rx_one(8'h22, 4'h4, 1'b0, 1'b1, 1'b0, 3'h1, 1'b1, 1'b0);
    rd(ADDR_STATUS, v);
    check("overrun held", {4'h0, v}, 12'h001);
    wr(ADDR_DATA, 8'h77);
    rd(ADDR_DATA, v);
    check("buffer not written", {4'h0, v}, 12'h022);
    rd(ADDR_STATUS, v);
    check("overrun cleared", {4'h0, v}, 12'h000);
    for (int i = 0; i < 16; i++) tx_one(8'($random(seed)), 4'(i));
    wr(ADDR_MODE, mode_of(1'b1, 1'b0, 4'h4, 1'b0));
    // Eight data bits and one stop: sampling more would swallow the next start edge.
    frame_bits = 4'h9;
    target = tx_pulses + 17;
    for (int k = 0; k < 17; k++) begin
      data_q[k] = 8'($random(seed));
      wr(ADDR_DATA, data_q[k]);
      @(posedge sys_clk_in);
      #1;
    end
    @(posedge sys_clk_in);
    #1;
    check("queue full", {11'h0, cpu_tx_ready_out}, 12'h000);
    wait_tx(target);
    check("queued frames", 12'(st.frames_q.size()), 12'd17);
    for (int k = 0; k < 17 && st.frames_q.size() > 0; k++) begin
      check("queued frame", st.frames_q.pop_front(), {4'h1, data_q[k]});
    end
    check("queue drained", {11'h0, cpu_tx_ready_out}, 12'h001);
    wr(ADDR_BAUD, 8'hFF);
    rd(ADDR_BAUD, v);
    check("baud", {4'h0, v}, 12'h07F);
    // Source clock over 8 and divider 17; the free-running prescaler trims up to 7 clocks.
    wr(ADDR_BAUD, 8'h11);
    wr(ADDR_DATA, 8'hFF);
    lo = 0;
    for (int k = 0; k < 400; k++) begin
      @(posedge sys_clk_in);
      if (txd_out === 1'b0) lo++;
    end
    check("start bit length", 12'((lo > (int'(BAUD_BASE_DIV) + 1) * 8 - 8) &&
          (lo <= (int'(BAUD_BASE_DIV) + 1) * 8)), 12'h001);
    results();
  end
endmodule : async_serial_port_test
`default_nettype wire
